// >>> common/dssp_pkg.sv
// Shared constants and types of the dual-slot pulse sampler
package dssp_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int unsigned TICK32K_HZ = 32_768;
	localparam int unsigned TICK32K_CYC = CLK_HZ / TICK32K_HZ;
	localparam int unsigned PROC_FIRST_US = 68;
	localparam int unsigned PROC_SECOND_US = 20;
	localparam int unsigned SLEEP_MIN_US = 200;
	localparam int unsigned PROC_FIRST_CYC = PROC_FIRST_US * CYC_PER_US;
	localparam int unsigned PROC_SECOND_CYC = PROC_SECOND_US * CYC_PER_US;
	localparam int unsigned SLEEP_MIN_CYC = SLEEP_MIN_US * CYC_PER_US;

	// ==========================================================
	// Data widths
	localparam int unsigned NUM_CH = 4;
	localparam int unsigned ADC_W = 14;
	localparam int unsigned BURST_W = 20;
	localparam int unsigned AVG_W = 27;
	localparam int unsigned RES_W = 29;

	// ==========================================================
	// Register map (8-bit register pointer, 16-bit words)
	localparam logic [7:0] REG_MODE = 8'h10;
	localparam logic [7:0] REG_SLOT_CTRL = 8'h11;
	localparam logic [7:0] REG_RATE_DIV = 8'h12;
	localparam logic [7:0] REG_ROUTE = 8'h14;
	localparam logic [7:0] REG_SHAPE_A = 8'h30;
	localparam logic [7:0] REG_CNT_PER_A = 8'h31;
	localparam logic [7:0] REG_SHAPE_B = 8'h35;
	localparam logic [7:0] REG_CNT_PER_B = 8'h36;
	localparam logic [7:0] REG_AFE_A = 8'h39;
	localparam logic [7:0] REG_AFE_B = 8'h3B;
	localparam logic [3:0] RESULT_PAGE = 4'h6;

	// Field positions
	localparam int unsigned OFFSET_LSB = 0;
	localparam int unsigned WIDTH_LSB = 8;
	localparam int unsigned PERIOD_LSB = 0;
	localparam int unsigned COUNT_LSB = 8;
	localparam int unsigned ROUTE_A_LSB = 4;
	localparam int unsigned ROUTE_B_LSB = 8;
	localparam int unsigned CTRL_EN_A = 0;
	localparam int unsigned CTRL_EN_B = 1;
	localparam int unsigned CTRL_SUM = 2;
	localparam int unsigned CTRL_WIDE = 3;
	localparam int unsigned CTRL_AVG_LSB = 4;

	// Values after reset
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [1:0] RST_MODE = 2'h0;

	// Codes
	localparam logic [3:0] ROUTE_PAIR = 4'h1;
	localparam logic [3:0] ROUTE_ALL = 4'h4;
	localparam logic [15:0] SAT16 = 16'hFFFF;

	typedef enum logic [1:0] {
		MODE_STANDBY = 2'h0,
		MODE_PROGRAM = 2'h1,
		MODE_SAMPLE = 2'h2
	} dssp_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_OFFSET = 3'b001,
		ST_PULSE = 3'b011,
		ST_GAP = 3'b010,
		ST_PROC = 3'b110,
		ST_SLEEP = 3'b111
	} dssp_state_t;

	typedef struct packed {
		logic [7:0] offsetUs;
		logic [7:0] widthUs;
		logic [7:0] periodUs;
		logic [7:0] count;
	} dssp_timing_t;

	typedef struct packed {
		logic [ADC_W-1:0] signal;
		logic [ADC_W-1:0] ambient;
	} dssp_chan_t;

endpackage : dssp_pkg

// >>> hw/dssp_sampler.sv
// Dual-slot pulse timing, accumulation and serial register access
`timescale 1ns/1ps
module dssp_sampler
	import dssp_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary bus address
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Serial register bus
	input wire logic scl,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// Front-end samples, one per channel
	input dssp_chan_t chanIn [NUM_CH],
	// Emitter and front-end control, result-ready strobe
	output logic ledPulse,
	output logic afeWindow,
	output logic ledSlot,
	output logic [3:0] routeSel,
	output logic sampleDone
);

	// ==========================================================
	// Declarations
	logic [1:0] mode_q;
	logic [15:0] slotCtrl_q, rateDiv_q, route_q;
	logic [15:0] shape_q [2];
	logic [15:0] cntPer_q [2];
	logic [15:0] afe_q [2];
	logic sclQ_q, sdaQ_q, active_q, reading_q, readPend_q, rdLo_q, sdaOe_q, sdaOut_q;
	logic [3:0] bitCnt_q;
	logic [1:0] byteIdx_q;
	logic [7:0] rxByte_q, ptr_q, wrHi_q, wrAddr_q;
	logic [15:0] txWord_q, wrData_q, nextWord;
	logic wrStb_q;
	logic [7:0] txByte;
	logic i2cStart, i2cStop, sclRise, sclFall;
	dssp_state_t state_q, stateD;
	logic slot_q, slotD;
	logic [4:0] usPre_q;
	logic [7:0] usCnt_q, pulseCnt_q, durUs;
	logic [15:0] stateCyc_q;
	logic usTick, timeUp, sampling, enA, enB;
	logic [9:0] tickPre_q;
	logic [15:0] rateCnt_q;
	logic periodDue_q, periodStart, tick32;
	dssp_timing_t tm;
	logic enterOffset, pulseEnd, procEnd, avgLast;
	logic [6:0] avgCnt_q [2];
	logic [2:0] avgLog2;
	logic [3:0] routeSel_q, chanMask;
	logic ledPulse_q, afeWindow_q, ledSlot_q, sampleDone_q;
	wire [AVG_W-1:0] outView [2][NUM_CH];
	wire [BURST_W-1:0] accView [NUM_CH];

	// ==========================================================
	// Functions
	function automatic logic [7:0] atLeastOne(input logic [7:0] v);
		return (v == 8'h00) ? 8'h01 : v;
	endfunction : atLeastOne

	function automatic dssp_timing_t slotTiming(input logic s);
		dssp_timing_t t;
		t.offsetUs = shape_q[s][OFFSET_LSB +: 8];
		t.widthUs = shape_q[s][WIDTH_LSB +: 8];
		t.periodUs = cntPer_q[s][PERIOD_LSB +: 8];
		t.count = cntPer_q[s][COUNT_LSB +: 8];
		return t;
	endfunction : slotTiming

	function automatic logic [3:0] routeMask(input logic [3:0] code);
		logic [3:0] m;
		m = 4'b0000;
		if (code == ROUTE_PAIR)
			m = 4'b1100;
		else if (code == ROUTE_ALL)
			m = 4'b1111;
		return m;
	endfunction : routeMask

	function automatic logic [15:0] readReg(input logic [7:0] a);
		logic [RES_W-1:0] v;
		logic [15:0] r;
		logic s;
		logic [1:0] c;
		s = a[3];
		c = a[2:1];
		r = 16'h0000;
		if (slotCtrl_q[CTRL_SUM])
			v = (c != 2'd0) ? '0 : RES_W'(outView[s][0]) + RES_W'(outView[s][1])
				+ RES_W'(outView[s][2]) + RES_W'(outView[s][3]);
		else
			v = RES_W'(outView[s][c]);
		if (a[7:4] == RESULT_PAGE)
		begin
			if (slotCtrl_q[CTRL_WIDE])
				r = a[0] ? {3'b000, v[RES_W-1:16]} : v[15:0];
			else if (!a[0])
				r = (v > RES_W'(SAT16)) ? SAT16 : v[15:0];
		end
		else
		begin
			case (a)
				REG_MODE: r = {14'h0000, mode_q};
				REG_SLOT_CTRL: r = slotCtrl_q;
				REG_RATE_DIV: r = rateDiv_q;
				REG_ROUTE: r = route_q;
				REG_SHAPE_A: r = shape_q[0];
				REG_CNT_PER_A: r = cntPer_q[0];
				REG_SHAPE_B: r = shape_q[1];
				REG_CNT_PER_B: r = cntPer_q[1];
				REG_AFE_A: r = afe_q[0];
				REG_AFE_B: r = afe_q[1];
				default: r = 16'h0000;
			endcase
		end
		return r;
	endfunction : readReg

	// ==========================================================
	// Register file, shape, count/period and AFE words kept per slot
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			mode_q <= RST_MODE;
			slotCtrl_q <= RST_WORD;
			rateDiv_q <= RST_WORD;
			route_q <= RST_WORD;
			for (int s = 0; s < 2; s++)
			begin
				shape_q[s] <= RST_WORD;
				cntPer_q[s] <= RST_WORD;
				afe_q[s] <= RST_WORD;
			end
		end
		else if (wrStb_q)
		begin
			case (wrAddr_q)
				REG_MODE: mode_q <= wrData_q[1:0];
				REG_SLOT_CTRL: slotCtrl_q <= wrData_q;
				REG_RATE_DIV: rateDiv_q <= wrData_q;
				REG_ROUTE: route_q <= wrData_q;
				REG_SHAPE_A: shape_q[0] <= wrData_q;
				REG_CNT_PER_A: cntPer_q[0] <= wrData_q;
				REG_SHAPE_B: shape_q[1] <= wrData_q;
				REG_CNT_PER_B: cntPer_q[1] <= wrData_q;
				REG_AFE_A: afe_q[0] <= wrData_q;
				REG_AFE_B: afe_q[1] <= wrData_q;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Serial slave, open-drain data line
	assign i2cStart = sclQ_q && scl && sdaQ_q && !sdaIn;
	assign i2cStop = sclQ_q && scl && !sdaQ_q && sdaIn;
	assign sclRise = !sclQ_q && scl;
	assign sclFall = sclQ_q && !scl;
	assign txByte = rdLo_q ? txWord_q[7:0] : txWord_q[15:8];
	// Procedural, so register edits reach the result without a pointer change
	always_comb
	begin
		nextWord = readReg(ptr_q + 8'd1);
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sclQ_q <= 1'b1;
			sdaQ_q <= 1'b1;
		end
		else
		begin
			sclQ_q <= scl;
			sdaQ_q <= sdaIn;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			active_q <= 1'b0;
			reading_q <= 1'b0;
			readPend_q <= 1'b0;
			rdLo_q <= 1'b0;
			sdaOe_q <= 1'b0;
			sdaOut_q <= 1'b0;
			bitCnt_q <= 4'd0;
			byteIdx_q <= 2'd0;
			rxByte_q <= 8'h00;
			ptr_q <= 8'h00;
			wrHi_q <= 8'h00;
			wrAddr_q <= 8'h00;
			wrData_q <= 16'h0000;
			wrStb_q <= 1'b0;
			txWord_q <= 16'h0000;
		end
		else
		begin
			wrStb_q <= 1'b0;
			if (i2cStart)
			begin
				active_q <= 1'b1;
				bitCnt_q <= 4'd0;
				byteIdx_q <= 2'd0;
				reading_q <= 1'b0;
				readPend_q <= 1'b0;
				sdaOe_q <= 1'b0;
			end
			else if (i2cStop)
			begin
				active_q <= 1'b0;
				reading_q <= 1'b0;
				readPend_q <= 1'b0;
				sdaOe_q <= 1'b0;
			end
			else if (active_q && sclRise)
			begin
				if (bitCnt_q < 4'd8)
				begin
					rxByte_q <= {rxByte_q[6:0], sdaIn};
					bitCnt_q <= bitCnt_q + 4'd1;
				end
				else if (bitCnt_q == 4'd9 && reading_q && sdaIn)
				begin
					// Master declined more data
					active_q <= 1'b0;
					reading_q <= 1'b0;
				end
			end
			else if (active_q && sclFall)
			begin
				if (bitCnt_q == 4'd8)
				begin
					bitCnt_q <= 4'd9;
					if (reading_q)
						sdaOe_q <= 1'b0;
					else
					begin
						byteIdx_q <= (byteIdx_q == 2'd3) ? 2'd2 : byteIdx_q + 2'd1;
						case (byteIdx_q)
							2'd0:
								if (rxByte_q[7:1] == DEV_ADDR)
								begin
									sdaOe_q <= 1'b1;
									readPend_q <= rxByte_q[0];
									txWord_q <= readReg(ptr_q);
									rdLo_q <= 1'b0;
								end
								else
									active_q <= 1'b0;
							2'd1:
							begin
								ptr_q <= rxByte_q;
								sdaOe_q <= 1'b1;
							end
							2'd2:
							begin
								wrHi_q <= rxByte_q;
								sdaOe_q <= 1'b1;
							end
							default:
							begin
								wrStb_q <= 1'b1;
								wrAddr_q <= ptr_q;
								wrData_q <= {wrHi_q, rxByte_q};
								ptr_q <= ptr_q + 8'd1;
								sdaOe_q <= 1'b1;
							end
						endcase
					end
				end
				else if (bitCnt_q == 4'd9)
				begin
					bitCnt_q <= 4'd0;
					if (readPend_q)
					begin
						reading_q <= 1'b1;
						readPend_q <= 1'b0;
						sdaOe_q <= ~txWord_q[15];
					end
					else if (reading_q && rdLo_q)
					begin
						// Whole word sent: move on, snapshot keeps both halves coherent
						rdLo_q <= 1'b0;
						ptr_q <= ptr_q + 8'd1;
						txWord_q <= nextWord;
						sdaOe_q <= ~nextWord[15];
					end
					else if (reading_q)
					begin
						rdLo_q <= 1'b1;
						sdaOe_q <= ~txWord_q[7];
					end
					else
						sdaOe_q <= 1'b0;
				end
				else if (reading_q)
					sdaOe_q <= ~txByte[3'd7 - bitCnt_q[2:0]];
			end
		end
	end

	// ==========================================================
	// Sample-period timer from the 32 kHz tick
	assign sampling = (mode_q == MODE_SAMPLE);
	assign enA = slotCtrl_q[CTRL_EN_A];
	assign enB = slotCtrl_q[CTRL_EN_B];
	assign tick32 = (tickPre_q == 10'(TICK32K_CYC - 1));
	assign periodStart = (state_q == ST_IDLE) && (stateD == ST_OFFSET);

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tickPre_q <= 10'd0;
			rateCnt_q <= 16'h0000;
			periodDue_q <= 1'b0;
		end
		else if (!sampling)
		begin
			tickPre_q <= 10'd0;
			rateCnt_q <= 16'h0000;
			periodDue_q <= 1'b0;
		end
		else
		begin
			tickPre_q <= tick32 ? 10'd0 : tickPre_q + 10'd1;
			if (tick32)
				rateCnt_q <= (rateCnt_q + 16'd1 >= rateDiv_q) ? 16'h0000 : rateCnt_q + 16'd1;
			// Set wins over the clear taken at period start
			periodDue_q <= (periodDue_q && !periodStart)
				|| (tick32 && rateCnt_q + 16'd1 >= rateDiv_q);
		end
	end

	// ==========================================================
	// Slot sequencer
	always_comb
	begin
		tm = slotTiming(slot_q);
	end
	assign usTick = (usPre_q == 5'(CYC_PER_US - 1));
	assign timeUp = usTick && (usCnt_q == durUs - 8'd1);

	always_comb
	begin
		durUs = 8'd1;
		stateD = state_q;
		slotD = slot_q;
		unique case (state_q)
			ST_IDLE:
				if (sampling && periodDue_q && (enA || enB))
				begin
					stateD = ST_OFFSET;
					slotD = !enA;
				end
			ST_OFFSET:
			begin
				durUs = atLeastOne(tm.offsetUs);
				if (timeUp)
					stateD = ST_PULSE;
			end
			ST_PULSE:
			begin
				durUs = atLeastOne(tm.widthUs);
				if (timeUp)
					stateD = ST_GAP;
			end
			ST_GAP:
			begin
				// Period is start to start; a width at or past it leaves one microsecond
				durUs = (tm.periodUs > tm.widthUs) ? tm.periodUs - tm.widthUs : 8'd1;
				if (timeUp)
					stateD = (pulseCnt_q >= atLeastOne(tm.count)) ? ST_PROC : ST_PULSE;
			end
			ST_PROC:
			begin
				durUs = slot_q ? 8'(PROC_SECOND_US) : 8'(PROC_FIRST_US);
				if (timeUp && !slot_q && enB)
				begin
					stateD = ST_OFFSET;
					slotD = 1'b1;
				end
				else if (timeUp)
					stateD = ST_SLEEP;
			end
			ST_SLEEP:
			begin
				durUs = 8'(SLEEP_MIN_US);
				if (timeUp)
					stateD = ST_IDLE;
			end
			default: stateD = ST_IDLE;
		endcase
		if (!sampling)
			stateD = ST_IDLE;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= ST_IDLE;
			slot_q <= 1'b0;
			usPre_q <= 5'd0;
			usCnt_q <= 8'd0;
			stateCyc_q <= 16'h0000;
		end
		else
		begin
			state_q <= stateD;
			slot_q <= slotD;
			// Restarting the prescaler on every change keeps durations exact
			usPre_q <= (stateD != state_q || usTick) ? 5'd0 : usPre_q + 5'd1;
			if (stateD != state_q)
				usCnt_q <= 8'd0;
			else if (usTick)
				usCnt_q <= usCnt_q + 8'd1;
			if (stateD != state_q)
				stateCyc_q <= 16'h0000;
			else if (stateCyc_q != 16'hFFFF)
				stateCyc_q <= stateCyc_q + 16'd1;
		end
	end

	// ==========================================================
	// Pulse counting, routing latch and averaging count
	assign enterOffset = (stateD == ST_OFFSET) && (state_q != ST_OFFSET);
	assign pulseEnd = (state_q == ST_PULSE) && timeUp && sampling;
	assign procEnd = (state_q == ST_PROC) && timeUp && sampling;
	assign avgLog2 = slotCtrl_q[CTRL_AVG_LSB +: 3];
	assign avgLast = ({1'b0, avgCnt_q[slot_q]} == ((8'd1 << avgLog2) - 8'd1));
	assign chanMask = routeMask(routeSel_q);

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pulseCnt_q <= 8'd0;
			routeSel_q <= 4'h0;
		end
		else if (enterOffset)
		begin
			pulseCnt_q <= 8'd0;
			routeSel_q <= slotD ? route_q[ROUTE_B_LSB +: 4] : route_q[ROUTE_A_LSB +: 4];
		end
		else if (pulseEnd)
			pulseCnt_q <= pulseCnt_q + 8'd1;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			avgCnt_q[0] <= 7'd0;
			avgCnt_q[1] <= 7'd0;
		end
		else if (!sampling)
		begin
			avgCnt_q[0] <= 7'd0;
			avgCnt_q[1] <= 7'd0;
		end
		else if (procEnd)
			avgCnt_q[slot_q] <= avgLast ? 7'd0 : avgCnt_q[slot_q] + 7'd1;
	end

	// ==========================================================
	// Per-channel burst and sample accumulation
	for (genvar c = 0; c < NUM_CH; c++)
	begin : gChan
		logic [BURST_W-1:0] acc_q;
		logic [AVG_W-1:0] sum_q [2];
		logic [AVG_W-1:0] out_q [2];
		logic [ADC_W-1:0] net;
		logic [BURST_W:0] accNext;

		assign net = (chanIn[c].signal > chanIn[c].ambient)
			? chanIn[c].signal - chanIn[c].ambient : '0;
		assign accNext = {1'b0, acc_q} + (BURST_W + 1)'(net);

		always_ff @(posedge mclk or posedge sys_rst)
		begin
			if (sys_rst)
				acc_q <= '0;
			else if (enterOffset)
				acc_q <= '0;
			else if (pulseEnd && chanMask[c])
				acc_q <= accNext[BURST_W] ? '1 : accNext[BURST_W-1:0];
		end

		// Sum over N samples may reach 27 bits; not divided back down
		always_ff @(posedge mclk or posedge sys_rst)
		begin
			if (sys_rst)
			begin
				for (int s = 0; s < 2; s++)
				begin
					sum_q[s] <= '0;
					out_q[s] <= '0;
				end
			end
			else if (procEnd && avgLast)
			begin
				out_q[slot_q] <= sum_q[slot_q] + AVG_W'(acc_q);
				sum_q[slot_q] <= '0;
			end
			else if (procEnd)
				sum_q[slot_q] <= sum_q[slot_q] + AVG_W'(acc_q);
		end

		assign outView[0][c] = out_q[0];
		assign outView[1][c] = out_q[1];
		assign accView[c] = acc_q;
	end

	// ==========================================================
	// Output flops
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ledPulse_q <= 1'b0;
			afeWindow_q <= 1'b0;
			ledSlot_q <= 1'b0;
			sampleDone_q <= 1'b0;
		end
		else
		begin
			ledPulse_q <= (stateD == ST_PULSE);
			afeWindow_q <= (stateD == ST_PULSE);
			ledSlot_q <= slotD;
			sampleDone_q <= procEnd && avgLast;
		end
	end

	assign sdaOut = sdaOut_q;
	assign sdaOe = sdaOe_q;
	assign ledPulse = ledPulse_q;
	assign afeWindow = afeWindow_q;
	assign ledSlot = ledSlot_q;
	assign routeSel = routeSel_q;
	assign sampleDone = sampleDone_q;

	// ==========================================================
	// Assertions
	sequence sFirstDone;
		(state_q == ST_PROC && !slot_q) ##1 (state_q != ST_PROC);
	endsequence

	sequence sProcLeave;
		(state_q == ST_PROC) && (stateD != ST_PROC) && sampling;
	endsequence

	a_led_sample_only: assert property (@(posedge mclk) disable iff (sys_rst)
		ledPulse_q |-> $past(mode_q) == MODE_SAMPLE) else $error("pulse outside sample mode");
	a_afe_window_sync: assert property (@(posedge mclk) disable iff (sys_rst)
		(ledPulse_q == afeWindow_q) && (afeWindow_q == (state_q == ST_PULSE)))
		else $error("pulse not inside sensing window");
	a_slot_order_ab: assert property (@(posedge mclk) disable iff (sys_rst)
		(sFirstDone ##0 $past(sampling && enB)) |-> (state_q == ST_OFFSET && slot_q))
		else $error("second slot did not follow first");
	a_pulse_count_range: assert property (@(posedge mclk) disable iff (sys_rst)
		(state_q == ST_PROC) |-> (pulseCnt_q == atLeastOne(tm.count) && pulseCnt_q != 8'd0))
		else $error("burst length wrong");
	a_acc_slot_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(state_q == ST_OFFSET) |-> (accView[0] == '0 && accView[3] == '0 && pulseCnt_q == 8'd0))
		else $error("accumulator not cleared at slot start");
	a_proc_time_len: assert property (@(posedge mclk) disable iff (sys_rst)
		sProcLeave |-> stateCyc_q == (slot_q ? 16'(PROC_SECOND_CYC - 1) : 16'(PROC_FIRST_CYC - 1)))
		else $error("processing time wrong");
	// Leaving sample mode may cut the sleep short; only a timed exit counts
	a_sleep_min_time: assert property (@(posedge mclk) disable iff (sys_rst)
		(state_q == ST_SLEEP && stateD == ST_IDLE && sampling) |-> stateCyc_q >= 16'(SLEEP_MIN_CYC - 1))
		else $error("sleep shorter than minimum");
	a_route_pair_mask: assert property (@(posedge mclk) disable iff (sys_rst)
		(state_q != ST_IDLE && state_q != ST_SLEEP && routeSel_q == ROUTE_PAIR)
		|-> (accView[0] == '0 && accView[1] == '0)) else $error("unrouted channel summed");
	a_unused_slot_skip: assert property (@(posedge mclk) disable iff (sys_rst)
		(periodStart && !enA) |=> slot_q) else $error("disabled first slot ran");
	a_result_after_proc: assert property (@(posedge mclk) disable iff (sys_rst)
		sampleDone_q |-> ($past(state_q) == ST_PROC && state_q != ST_PROC))
		else $error("result moved before processing end");

endmodule : dssp_sampler

// >>> verif/dssp_host.sv
// Serial bus master model standing in for the host processor
`timescale 1ns/1ps
module dssp_host
#(
	parameter logic [6:0] ADDR = 7'h2A
)
(
	// Clock and resolved data wire
	input wire logic mclk,
	input wire logic sda,
	// Bus drive, oe high pulls data low
	output logic scl,
	output logic oe
);
	// ==========================================================
	// Bus phases, clock held high three clocks and low four
	initial
	begin
		scl = 1'b1;
		oe = 1'b0;
	end
	task automatic t(input int n);
		repeat (n) @(posedge mclk);
		#5;
	endtask : t
	task automatic bt(input logic b, output logic r);
		oe = ~b;
		t(3);
		scl = 1'b1;
		t(3);
		r = sda;
		scl = 1'b0;
		t(1);
	endtask : bt
	task automatic by(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--)
			bt(d[i], q[i]);
		bt(m, a);
	endtask : by
	task automatic st();
		oe = 1'b0;
		t(1);
		scl = 1'b1;
		t(3);
		oe = 1'b1;
		t(3);
		scl = 1'b0;
		t(1);
	endtask : st
	task automatic sp();
		oe = 1'b1;
		t(1);
		scl = 1'b1;
		t(3);
		oe = 1'b0;
		t(3);
	endtask : sp
	task automatic wr(input logic [7:0] p, input logic [15:0] d, output logic a);
		logic [7:0] q;
		logic [3:0] k;
		st();
		by({ADDR, 1'b0}, 1'b1, q, k[0]);
		by(p, 1'b1, q, k[1]);
		by(d[15:8], 1'b1, q, k[2]);
		by(d[7:0], 1'b1, q, k[3]);
		sp();
		a = |k;
	endtask : wr
	task automatic rd(input logic [7:0] p, output logic [15:0] d);
		logic [7:0] q;
		logic a;
		st();
		by({ADDR, 1'b0}, 1'b1, q, a);
		by(p, 1'b1, q, a);
		st();
		by({ADDR, 1'b1}, 1'b1, q, a);
		by(8'hFF, 1'b0, d[15:8], a);
		by(8'hFF, 1'b1, d[7:0], a);
		sp();
	endtask : rd
endmodule : dssp_host

// >>> verif/testbench.sv
// Self-checking bench of the dual-slot pulse sampler
`timescale 1ns/1ps
module testbench;
	import dssp_pkg::*;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic scl, hOe, sdaOut, sdaOe, ledPulse, afeWindow, ledSlot, sampleDone, ack, prevLed;
	logic [3:0] routeSel;
	logic [15:0] rv;
	logic [7:0] q;
	dssp_chan_t chanIn [NUM_CH];
	wire logic sdaLine = ~(sdaOe | hOe);
	int err_count = 0, n_checks = 0, seed = 37980;
	int cyc = 0, lastRise = 0, lastFall = 0, nRise = 0, total = 0, ca, cb, t0, es;
	dssp_sampler uut (.mclk(mclk), .sys_rst(sys_rst), .scl(scl), .sdaIn(sdaLine),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .chanIn(chanIn), .ledPulse(ledPulse),
		.afeWindow(afeWindow), .ledSlot(ledSlot), .routeSel(routeSel), .sampleDone(sampleDone));
	dssp_host host (.mclk(mclk), .sda(sdaLine), .scl(scl), .oe(hOe));
	// ==========================================================
	// Clock, watchdog, checking
	initial forever #25 mclk = ~mclk;
	initial
	begin
		repeat (90000) @(posedge mclk);
		err_count++;
		report_and_stop();
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	// Pulse width 2 us, period 4 us, so each pulse is 40 cycles high in 80
	always @(negedge mclk)
	begin
		cyc++;
		if (ledPulse === 1'b1 && !prevLed)
		begin
			if (nRise > 0) check(cyc - lastRise, 80);
			lastRise = cyc;
			nRise++;
			total++;
		end
		if (ledPulse !== 1'b1 && prevLed)
		begin
			check(cyc - lastRise, 40);
			lastFall = cyc;
		end
		if (ledPulse === 1'b1) check(afeWindow, 1'b1);
		prevLed = (ledPulse === 1'b1);
	end
	task automatic wr(input logic [7:0] p, input logic [15:0] d);
		host.wr(p, d, ack);
		check(ack, 1'b0);
	endtask : wr
	task automatic rdc(input logic [7:0] p, input logic [15:0] e);
		host.rd(p, rv);
		check(rv, e);
	endtask : rdc
	function automatic logic [15:0] ev(input int ch, input logic [3:0] code, input int n);
		int d;
		d = int'(chanIn[ch].signal) - int'(chanIn[ch].ambient);
		d = (d < 0) ? 0 : d;
		if (code == ROUTE_ALL || (code == ROUTE_PAIR && ch >= 2))
			return 16'(n * d);
		return 16'h0000;
	endfunction : ev
	// Slot end: done follows the last pulse's off time plus processing
	task automatic wdone(input logic s, input int n, input logic [3:0] c, input int g);
		int k;
		k = 0;
		while (sampleDone !== 1'b1 && k < 20000)
		begin
			@(negedge mclk);
			#1;
			k++;
		end
		check(sampleDone, 1'b1);
		check(ledSlot, s);
		check(nRise, n);
		check(routeSel, c);
		check((cyc - lastFall) inside {[g + 40 : g + 43]}, 1'b1);
		nRise = 0;
		@(negedge mclk);
	endtask : wdone
	// ==========================================================
	// Main sequence
	initial
	begin
		for (int i = 0; i < NUM_CH; i++)
			chanIn[i] = 28'($random(seed));
		ca = 1 + {$random(seed)} % 4;
		cb = 1;
		repeat (12) @(posedge mclk);
		#5 sys_rst = 1'b0;
		check(sdaOut, 1'b0);
		rdc(REG_CNT_PER_A, RST_WORD);
		rdc(8'h20, 16'h0000);
		host.st();
		host.by(8'h56, 1'b1, q, ack);
		host.sp();
		check(ack, 1'b1);
		wr(REG_SHAPE_A, 16'h0203);
		wr(REG_SHAPE_B, 16'h0203);
		wr(REG_CNT_PER_A, {8'(ca), 8'h04});
		wr(REG_CNT_PER_B, {8'(cb), 8'h04});
		rdc(REG_CNT_PER_A, {8'(ca), 8'h04});
		wr(REG_ROUTE, 16'h0140);
		wr(REG_SLOT_CTRL, 16'h0003);
		wr(REG_RATE_DIV, 16'h000C);
		nRise = 0;
		wr(REG_MODE, 16'h0002);
		// Slot two is already latched when slot one's result lands
		wdone(1'b1, ca, ROUTE_PAIR, PROC_FIRST_CYC);
		wdone(1'b1, cb, ROUTE_PAIR, PROC_SECOND_CYC);
		t0 = cyc;
		while (ledPulse !== 1'b1 && cyc - t0 < 20000) @(negedge mclk);
		check(cyc - t0 >= SLEEP_MIN_CYC, 1'b1);
		// Let this period finish so the mode change lands in sleep, not mid-pulse
		wdone(1'b1, ca, ROUTE_PAIR, PROC_FIRST_CYC);
		wdone(1'b1, cb, ROUTE_PAIR, PROC_SECOND_CYC);
		wr(REG_MODE, 16'h0001);
		es = 0;
		for (int c = 0; c < NUM_CH; c++)
		begin
			rdc(8'(8'h60 + 2 * c), ev(c, ROUTE_ALL, ca));
			rdc(8'(8'h68 + 2 * c), ev(c, ROUTE_PAIR, cb));
			es += int'(ev(c, ROUTE_ALL, ca));
		end
		wr(REG_SLOT_CTRL, 16'h000C);
		rdc(8'h60, 16'(es));
		rdc(8'h61, 16'(es >> 16));
		rdc(8'h62, 16'h0000);
		wr(REG_SLOT_CTRL, 16'h0002);
		wr(REG_ROUTE, 16'h0410);
		nRise = 0;
		wr(REG_MODE, 16'h0002);
		wdone(1'b1, cb, ROUTE_ALL, PROC_SECOND_CYC);
		wr(REG_MODE, 16'h0000);
		for (int c = 0; c < NUM_CH; c++)
			rdc(8'(8'h68 + 2 * c), ev(c, ROUTE_ALL, cb));
		t0 = total;
		repeat (8000) @(negedge mclk);
		check(total, t0);
		report_and_stop();
	end
endmodule : testbench
